/* pmdp_defs.vh */
/*
 Constants for the power monitor datapath: register offsets on the APB
 bus, field positions and the setup register reset value.
 Assumes inclusion by bare name from the design file.
*/
`ifndef PMDP_DEFS_VH
`define PMDP_DEFS_VH

// Register byte offsets
`define PMDP_SETUP_OFS      8'h00
`define PMDP_TRIGGER_OFS    8'h04
`define PMDP_STATUS_OFS     8'h08
`define PMDP_CURRENT_OFS    8'h0C
`define PMDP_VOLTAGE_OFS    8'h10
`define PMDP_AUX_OFS        8'h14
`define PMDP_POWER_OFS      8'h18
`define PMDP_MAX_VIN_OFS    8'h1C
`define PMDP_MAX_AUXILIARY_VOLTAGE_INPUT_OFS   8'h20
`define PMDP_MIN_CUR_OFS    8'h24
`define PMDP_MAX_CUR_OFS    8'h28
`define PMDP_MIN_PWR_OFS    8'h2C
`define PMDP_MAX_PWR_OFS    8'h30
`define PMDP_ENERGY_OFS     8'h34
`define PMDP_ENERGY_HI_OFS  8'h38
`define PMDP_COUNT_OFS      8'h3C

// Setup register fields
`define PMDP_AVG_LSB        0
`define PMDP_CONT_BIT       3
`define PMDP_EXT_TRIG_BIT   4
`define PMDP_SETUP_RESET    5'h00

// Trigger register fields
`define PMDP_CONVERT_BIT    0
`define PMDP_CLEAR_PEAK_BIT 1
`define PMDP_CLEAR_ACC_BIT  2

// Status register fields
`define PMDP_BUSY_BIT       0
`define PMDP_DONE_BIT       1

`endif

/* pmdp_top.v */
/*
 Digital back end of a current/voltage/power monitor: averaging over
 2^N samples, per-sample power, power averaging, energy accumulation,
 extreme trackers, APB register slave.
 Assumes an ADC front end that presents one sample triple (current,
 primary voltage, auxiliary voltage) with a one-cycle valid strobe, on
 the same clock. The external trigger pin is asynchronous.
*/
`timescale 1ns/1ps
`include "pmdp_defs.vh"
`default_nettype none

module pmdp_top #(
    parameter DW = 12,
    parameter CW = 8
) (
    input  wire          clk_in,
    input  wire          rst_n_in,
    input  wire          psel_in,
    input  wire          penable_in,
    input  wire          pwrite_in,
    input  wire [7:0]    paddr_in,
    input  wire [31:0]   pwdata_in,
    output reg  [31:0]   prdata_out,
    output reg           pready_out,
    output reg           pslverr_out,
    input  wire          sample_valid_in,
    input  wire [DW-1:0] sample_current_in,
    input  wire [DW-1:0] sample_voltage_in,
    input  wire [DW-1:0] sample_aux_in,
    input  wire          conversion_trigger_input,
    output reg           adc_run_out
);
    localparam PW  = 2 * DW;
    localparam AW  = PW + 7;
    localparam EW  = 32;
    localparam ST_IDLE = 1'b0;
    localparam ST_RUN  = 1'b1;

    reg  [4:0]    setup;
    reg           state;
    reg           done;
    reg  [2:0]    trig_sync;
    reg           trig_level;
    reg  [7:0]    avg_cnt;
    reg  [DW+6:0] sum_cur;
    reg  [DW+6:0] sum_vin;
    reg  [DW+6:0] sum_aux;
    reg  [AW-1:0] sum_pwr;
    reg  [DW-1:0] res_cur;
    reg  [DW-1:0] res_vin;
    reg  [DW-1:0] res_aux;
    reg  [PW-1:0] res_pwr;
    reg  [DW-1:0] max_vin;
    reg  [DW-1:0] max_aux;
    reg  [DW-1:0] min_cur;
    reg  [DW-1:0] max_cur;
    reg  [PW-1:0] min_pwr;
    reg  [PW-1:0] max_pwr;
    reg  [EW-1:0] energy;
    reg  [CW-1:0] rollover;
    reg  [31:0]   pwr_count;
    reg  [31:0]   snap_count;
    reg  [CW-1:0] snap_roll;
    reg           result_new;

    wire [2:0]    avg_n      = setup[`PMDP_AVG_LSB +: 3];
    wire          cont_mode  = setup[`PMDP_CONT_BIT];
    wire          ext_en     = setup[`PMDP_EXT_TRIG_BIT];
    wire          apb_wr     = psel_in & penable_in & pwrite_in;
    wire          sw_convert = apb_wr & (paddr_in == `PMDP_TRIGGER_OFS)
                               & pwdata_in[`PMDP_CONVERT_BIT];
    wire          clr_peak   = apb_wr & (paddr_in == `PMDP_TRIGGER_OFS)
                               & pwdata_in[`PMDP_CLEAR_PEAK_BIT];
    wire          clr_acc    = apb_wr & (paddr_in == `PMDP_TRIGGER_OFS)
                               & pwdata_in[`PMDP_CLEAR_ACC_BIT];
    // Rising pin edge counts once the second and third stages agree on a new high level
    wire          pin_rise   = (trig_sync[2] == trig_sync[1]) & trig_sync[1] & ~trig_level;
    wire          start      = sw_convert | (ext_en & pin_rise);
    wire          take       = sample_valid_in & (state == ST_RUN);
    wire [PW-1:0] prod       = sample_voltage_in * sample_current_in;
    wire [7:0]    last_idx   = (8'h01 << avg_n) - 8'h01;
    wire          last       = take & (avg_cnt == last_idx);
    wire [DW+6:0] nx_cur     = sum_cur + {7'h00, sample_current_in};
    wire [DW+6:0] nx_vin     = sum_vin + {7'h00, sample_voltage_in};
    wire [DW+6:0] nx_aux     = sum_aux + {7'h00, sample_aux_in};
    wire [AW-1:0] nx_pwr     = sum_pwr + {7'h00, prod};
    wire [DW+6:0] avg_cur    = nx_cur >> avg_n;
    wire [DW+6:0] avg_vin    = nx_vin >> avg_n;
    wire [DW+6:0] avg_aux    = nx_aux >> avg_n;
    wire [AW-1:0] avg_pwr    = nx_pwr >> avg_n;
    wire [EW:0]   next_energy = {1'b0, energy} + {{(EW-PW+1){1'b0}}, prod};

    // Pin synchroniser; only stages two and three are looked at
    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            trig_sync  <= 3'h0;
            trig_level <= 1'b0;
        end else begin
            trig_sync <= {trig_sync[1:0], conversion_trigger_input};
            if (trig_sync[2] == trig_sync[1]) begin
                trig_level <= trig_sync[1];
            end
        end
    end

    // Sequencer: continuous mode never leaves RUN, single shot stops after one result
    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state       <= ST_IDLE;
            done        <= 1'b0;
            adc_run_out <= 1'b0;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (cont_mode | start) begin
                        state <= ST_RUN;
                        done  <= 1'b0;
                    end
                end
                ST_RUN: begin
                    if (last & ~cont_mode) begin
                        state <= ST_IDLE;
                        done  <= 1'b1;
                    end
                end
                default: state <= ST_IDLE;
            endcase
            adc_run_out <= (state == ST_RUN) & ~(last & ~cont_mode);
        end
    end

    // Averaging accumulators for all three channels and for power
    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            avg_cnt    <= 8'h00;
            sum_cur    <= {(DW+7){1'b0}};
            sum_vin    <= {(DW+7){1'b0}};
            sum_aux    <= {(DW+7){1'b0}};
            sum_pwr    <= {AW{1'b0}};
            res_cur    <= {DW{1'b0}};
            res_vin    <= {DW{1'b0}};
            res_aux    <= {DW{1'b0}};
            res_pwr    <= {PW{1'b0}};
            result_new <= 1'b0;
        end else begin
            result_new <= last;
            if (state == ST_IDLE) begin
                avg_cnt <= 8'h00;
                sum_cur <= {(DW+7){1'b0}};
                sum_vin <= {(DW+7){1'b0}};
                sum_aux <= {(DW+7){1'b0}};
                sum_pwr <= {AW{1'b0}};
            end else if (last) begin
                avg_cnt <= 8'h00;
                sum_cur <= {(DW+7){1'b0}};
                sum_vin <= {(DW+7){1'b0}};
                sum_aux <= {(DW+7){1'b0}};
                sum_pwr <= {AW{1'b0}};
                res_cur <= avg_cur[DW-1:0];
                res_vin <= avg_vin[DW-1:0];
                res_aux <= avg_aux[DW-1:0];
                res_pwr <= avg_pwr[PW-1:0];
            end else if (take) begin
                avg_cnt <= avg_cnt + 8'h01;
                sum_cur <= nx_cur;
                sum_vin <= nx_vin;
                sum_aux <= nx_aux;
                sum_pwr <= nx_pwr;
            end
        end
    end

    // Energy accumulation per power sample; a clear in the same cycle as a sample restarts from that sample
    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            energy    <= {EW{1'b0}};
            rollover  <= {CW{1'b0}};
            pwr_count <= 32'h00000000;
        end else if (take) begin
            energy    <= clr_acc ? {{(EW-PW){1'b0}}, prod} : next_energy[EW-1:0];
            pwr_count <= clr_acc ? 32'h00000001 : pwr_count + 32'h00000001;
            if (clr_acc) begin
                rollover <= {CW{1'b0}};
            end else if (next_energy[EW]) begin
                rollover <= rollover + {{(CW-1){1'b0}}, 1'b1};
            end
        end else if (clr_acc) begin
            energy    <= {EW{1'b0}};
            rollover  <= {CW{1'b0}};
            pwr_count <= 32'h00000000;
        end
    end

    // Extreme trackers, checked on each new averaged result
    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            max_vin <= {DW{1'b0}};
            max_aux <= {DW{1'b0}};
            min_cur <= {DW{1'b1}};
            max_cur <= {DW{1'b0}};
            min_pwr <= {PW{1'b1}};
            max_pwr <= {PW{1'b0}};
        end else begin
            if (clr_peak) begin
                max_vin <= {DW{1'b0}};
                max_aux <= {DW{1'b0}};
                min_cur <= {DW{1'b1}};
                max_cur <= {DW{1'b0}};
                min_pwr <= {PW{1'b1}};
                max_pwr <= {PW{1'b0}};
            end
            // A result landing with a clear survives it, so no reading is lost
            if (result_new) begin
                if (clr_peak | (res_vin > max_vin)) max_vin <= res_vin;
                if (clr_peak | (res_aux > max_aux)) max_aux <= res_aux;
                if (clr_peak | (res_cur < min_cur)) min_cur <= res_cur;
                if (clr_peak | (res_cur > max_cur)) max_cur <= res_cur;
                if (clr_peak | (res_pwr < min_pwr)) min_pwr <= res_pwr;
                if (clr_peak | (res_pwr > max_pwr)) max_pwr <= res_pwr;
            end
        end
    end

    // APB slave: one wait-free access phase; energy read snapshots count and rollover
    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            setup       <= `PMDP_SETUP_RESET;
            prdata_out  <= 32'h00000000;
            pready_out  <= 1'b0;
            pslverr_out <= 1'b0;
            snap_count  <= 32'h00000000;
            snap_roll   <= {CW{1'b0}};
        end else begin
            pready_out  <= psel_in & ~penable_in;
            pslverr_out <= 1'b0;
            if (psel_in & ~penable_in) begin
                prdata_out <= 32'h00000000;
                case (paddr_in)
                    `PMDP_SETUP_OFS:    prdata_out <= {27'h0000000, setup};
                    `PMDP_TRIGGER_OFS:  prdata_out <= 32'h00000000;
                    `PMDP_STATUS_OFS:   prdata_out <= {30'h00000000, done, state};
                    `PMDP_CURRENT_OFS:  prdata_out <= {{(32-DW){1'b0}}, res_cur};
                    `PMDP_VOLTAGE_OFS:  prdata_out <= {{(32-DW){1'b0}}, res_vin};
                    `PMDP_AUX_OFS:      prdata_out <= {{(32-DW){1'b0}}, res_aux};
                    `PMDP_POWER_OFS:    prdata_out <= {{(32-PW){1'b0}}, res_pwr};
                    `PMDP_MAX_VIN_OFS:  prdata_out <= {{(32-DW){1'b0}}, max_vin};
                    `PMDP_MAX_AUXILIARY_VOLTAGE_INPUT_OFS: prdata_out <= {{(32-DW){1'b0}}, max_aux};
                    `PMDP_MIN_CUR_OFS:  prdata_out <= {{(32-DW){1'b0}}, min_cur};
                    `PMDP_MAX_CUR_OFS:  prdata_out <= {{(32-DW){1'b0}}, max_cur};
                    `PMDP_MIN_PWR_OFS:  prdata_out <= {{(32-PW){1'b0}}, min_pwr};
                    `PMDP_MAX_PWR_OFS:  prdata_out <= {{(32-PW){1'b0}}, max_pwr};
                    `PMDP_ENERGY_OFS: begin
                        prdata_out <= energy;
                        snap_count <= pwr_count;
                        snap_roll  <= rollover;
                    end
                    `PMDP_ENERGY_HI_OFS: prdata_out <= {{(32-CW){1'b0}}, snap_roll};
                    `PMDP_COUNT_OFS:    prdata_out <= snap_count;
                    default:            pslverr_out <= 1'b1;
                endcase
            end
            if (apb_wr & (paddr_in == `PMDP_SETUP_OFS)) begin
                setup <= pwdata_in[4:0];
            end
        end
    end
endmodule // pmdp_top

`default_nettype wire

/* pmdp_monitor.sv */
/* Checker for pmdp_top: bus timing, setup readback, sequencer starts.
   Assumes binding to pmdp_top and a master that holds each request. */
`timescale 1ns/1ps
`default_nettype none
module pmdp_monitor (
    input wire logic        clk_in,
    input wire logic        rst_n_in,
    input wire logic        psel_in,
    input wire logic        penable_in,
    input wire logic        pwrite_in,
    input wire logic [7:0]  paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire logic [31:0] prdata_out,
    input wire logic        pready_out,
    input wire logic        pslverr_out,
    input wire logic        sample_valid_in,
    input wire logic        conversion_trigger_input,
    input wire logic        adc_run_out
);
    logic [4:0] setup;
    wire        su = psel_in && !penable_in;
    wire        wr = psel_in && penable_in && pwrite_in && pready_out;
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    // Shadow of the setup register, so starts can be judged by mode
    always_ff @(posedge clk_in or negedge rst_n_in)
        if (!rst_n_in) setup <= 5'h00;
        else if (wr && paddr_in == 8'h00) setup <= pwdata_in[4:0];
    ready_next_a: assert property (su |=> pready_out)
        else $error("no ready after setup");
    ready_pulse_a: assert property (pready_out |=> !pready_out)
        else $error("ready held too long");
    ready_access_a: assert property (pready_out |-> psel_in && penable_in)
        else $error("ready outside access");
    err_ready_a: assert property (pslverr_out |-> pready_out)
        else $error("error without ready");
    err_unmapped_a: assert property (su && paddr_in >= 8'h40 |=> pslverr_out)
        else $error("unmapped access not refused");
    err_mapped_a: assert property (su && paddr_in < 8'h40 && paddr_in[1:0] == 2'h0
        |=> !pslverr_out) else $error("mapped access refused");
    setup_read_a: assert property (pready_out && !pwrite_in && paddr_in == 8'h00
        |-> prdata_out[4:0] == setup) else $error("setup readback wrong");
    convert_start_a: assert property (wr && paddr_in == 8'h04 && pwdata_in[0]
        && !setup[3] && !adc_run_out |-> ##[1:3] adc_run_out) else $error("no start");
    pin_start_a: assert property ($rose(conversion_trigger_input) && setup[4]
        && !setup[3] && !adc_run_out |-> ##[1:8] adc_run_out) else $error("no pin start");
    one_shot_a: assert property (sample_valid_in && adc_run_out && setup == 5'h10
        |-> ##[1:3] !adc_run_out) else $error("single shot overran");
endmodule // pmdp_monitor
bind pmdp_top pmdp_monitor chk (.clk_in, .rst_n_in, .psel_in, .penable_in, .pwrite_in,
    .paddr_in, .pwdata_in, .prdata_out, .pready_out, .pslverr_out, .sample_valid_in,
    .conversion_trigger_input, .adc_run_out);
`default_nettype wire

/* pmdp_adc_model.sv */
/* Behavioural converter front end feeding pmdp_top with sample triples.
   Assumes the run request is a level on the same clock. */
`timescale 1ns/1ps
`default_nettype none
module pmdp_adc_model #(
    parameter GAP = 3
) (
    input  wire logic        clk_in,
    input  wire logic        rst_n_in,
    input  wire logic        run_in,
    input  wire logic [11:0] cur_base_in,
    input  wire logic [11:0] volt_base_in,
    output var  logic        valid_out,
    output var  logic [11:0] cur_out,
    output var  logic [11:0] volt_out,
    output var  logic [11:0] aux_out
);
    logic [7:0] gap;
    logic [7:0] idx;
    // One sample every GAP+1 cycles while running; index ramps the values
    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            gap <= 8'h00;
            idx <= 8'h00;
            valid_out <= 1'b0;
        end else begin
            valid_out <= run_in && gap == GAP;
            gap <= (!run_in || gap == GAP) ? 8'h00 : gap + 8'h01;
            idx <= run_in ? idx + {7'h00, valid_out} : 8'h00;
        end
    end
    // Data lines show the inverse between strobes, never a stale value
    assign cur_out  = {12{!valid_out}} ^ (cur_base_in + {4'h0, idx});
    assign volt_out = {12{!valid_out}} ^ (volt_base_in + {3'h0, idx, 1'b0});
    assign aux_out  = {12{!valid_out}} ^ (cur_base_in + 12'h100 + {4'h0, idx});
endmodule // pmdp_adc_model
`default_nettype wire

/* tb.sv */
/* Self-checking bench for pmdp_top over APB, with a converter model.
   Assumes the one-cycle access answer of the slave. */
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clk_in, rst_n_in, psel_in, penable_in, pwrite_in, pready_out, pslverr_out;
    logic [7:0] paddr_in;
    logic [31:0] pwdata_in, prdata_out;
    logic sample_valid_in, conversion_trigger_input, adc_run_out;
    logic [11:0] sample_current_in, sample_voltage_in, sample_aux_in, cb, vb;
    int n_mismatch = 0;
    int checks = 0;
    pmdp_top dut (.clk_in, .rst_n_in, .psel_in, .penable_in, .pwrite_in, .paddr_in,
        .pwdata_in, .prdata_out, .pready_out, .pslverr_out, .sample_valid_in,
        .sample_current_in, .sample_voltage_in, .sample_aux_in,
        .conversion_trigger_input, .adc_run_out);
    pmdp_adc_model #(.GAP(3)) adc (.clk_in, .rst_n_in, .run_in(adc_run_out),
        .cur_base_in(cb), .volt_base_in(vb), .valid_out(sample_valid_in),
        .cur_out(sample_current_in), .volt_out(sample_voltage_in), .aux_out(sample_aux_in));
    // Free-running 200 MHz clock
    initial begin
        clk_in = 1'b0;
        forever #2.5 clk_in = ~clk_in;
    end
    task summarize;
        if (n_mismatch == 0 && checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task fail(input string m);
        n_mismatch++;
        $display("MISMATCH %0t %s", $time, m);
    endtask
    // One transfer; an idle edge first keeps back-to-back calls race free
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
             output logic [31:0] q, output logic e);
        int n;
        n = 0;
        @(posedge clk_in);
        {psel_in, penable_in, pwrite_in, paddr_in, pwdata_in} <= {2'b10, w, a, d};
        @(posedge clk_in);
        penable_in <= 1'b1;
        do begin
            @(posedge clk_in);
            n++;
        end while (pready_out !== 1'b1 && n < 20);
        if (n >= 20) begin
            fail("bus hang");
            summarize;
        end else begin
            q = prdata_out;
            e = pslverr_out;
            psel_in <= 1'b0;
            penable_in <= 1'b0;
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        apb(1'b1, a, d, q, e);
    endtask
    task chk(input logic [7:0] a, input logic [31:0] x, input logic ee);
        logic [31:0] q;
        logic e;
        apb(1'b0, a, 32'h0, q, e);
        checks++;
        if (e !== ee || (!ee && q !== x)) fail($sformatf("addr %h got %h", a, q));
    endtask
    // Waits for one sequencer run to begin and end, then for results to land
    task wait_run;
        int n;
        n = 0;
        while (adc_run_out !== 1'b1 && n < 50) begin
            @(posedge clk_in);
            n++;
        end
        if (adc_run_out !== 1'b1) n = 500; // A run that never began is a hang too
        while (adc_run_out !== 1'b0 && n < 500) begin
            @(posedge clk_in);
            n++;
        end
        if (n >= 500) begin
            fail("run hang");
            summarize;
        end else begin
            repeat (3) @(posedge clk_in);
        end
    endtask
    // Main sequence: reset, two single shots, clears, continuous start
    initial begin
        {psel_in, penable_in, pwrite_in, paddr_in, pwdata_in} = '0;
        {rst_n_in, conversion_trigger_input} = 2'b00;
        cb = 12'h005;
        vb = 12'h003;
        repeat (20) @(posedge clk_in);
        rst_n_in <= 1'b1;
        chk(8'h00, 32'h0, 1'b0);
        chk(8'h28, 32'h0, 1'b0);
        chk(8'h40, 32'h0, 1'b1);
        wr(8'h00, 32'h1);
        wr(8'h04, 32'h1);
        wait_run;
        chk(8'h08, 32'h2, 1'b0);
        chk(8'h0C, 32'h5, 1'b0);
        chk(8'h10, 32'h4, 1'b0);
        chk(8'h14, 32'h105, 1'b0);
        chk(8'h18, 32'h16, 1'b0);
        chk(8'h34, 32'h2D, 1'b0);
        chk(8'h3C, 32'h2, 1'b0);
        chk(8'h38, 32'h0, 1'b0);
        cb <= 12'h009;
        vb <= 12'h002;
        wr(8'h00, 32'h10);
        conversion_trigger_input <= 1'b1;
        wait_run;
        conversion_trigger_input <= 1'b0;
        chk(8'h18, 32'h12, 1'b0);
        chk(8'h34, 32'h3F, 1'b0);
        chk(8'h3C, 32'h3, 1'b0);
        chk(8'h1C, 32'h4, 1'b0);
        chk(8'h20, 32'h109, 1'b0);
        chk(8'h24, 32'h5, 1'b0);
        chk(8'h28, 32'h9, 1'b0);
        chk(8'h2C, 32'h12, 1'b0);
        chk(8'h30, 32'h16, 1'b0);
        wr(8'h04, 32'h6);
        chk(8'h28, 32'h0, 1'b0);
        chk(8'h1C, 32'h0, 1'b0);
        chk(8'h34, 32'h0, 1'b0);
        chk(8'h3C, 32'h0, 1'b0);
        wr(8'h00, 32'h8);
        wr(8'h04, 32'h1);
        repeat (30) @(posedge clk_in);
        chk(8'h08, 32'h1, 1'b0);
        summarize;
    end
endmodule // tb
`default_nettype wire
